// file: design/ssq_pkg.sv
// constants, register map and state type of the brake and stop sequencer
package ssq_pkg;
	// register byte offsets
	localparam int          ADDR_W     = 6;
	localparam logic [5:0]  OFF_CTRL   = 6'h00;
	localparam logic [5:0]  OFF_DELAY  = 6'h04;
	localparam logic [5:0]  OFF_SPEED  = 6'h08;
	localparam logic [5:0]  OFF_WAIT   = 6'h0C;
	localparam logic [5:0]  OFF_MON_A  = 6'h10;
	localparam logic [5:0]  OFF_MON_B  = 6'h14;
	localparam logic [5:0]  OFF_MAXSPD = 6'h18;
	localparam logic [5:0]  OFF_STATUS = 6'h1C;
	// control register fields, two bits each
	localparam int          CTRL_CC_LSB = 0;
	localparam int          CTRL_SM_LSB = 2;
	localparam int          CTRL_BT_LSB = 4;
	localparam logic [1:0]  CC_RST      = 2'h0;
	localparam logic [1:0]  SM_RST      = 2'h0;
	localparam logic [1:0]  BT_RST      = 2'h1;
	// stop modes
	localparam logic [1:0]  SM_DB_HOLD  = 2'h0;
	localparam logic [1:0]  SM_DB_FREE  = 2'h1;
	// timing fields, in steps of one tick
	localparam int          DELAY_W     = 6;
	localparam logic [5:0]  DELAY_MAX   = 6'h32;
	localparam logic [5:0]  DELAY_RST   = 6'h00;
	localparam int          WAIT_W      = 7;
	localparam logic [6:0]  WAIT_MIN    = 7'h0A;
	localparam logic [6:0]  WAIT_MAX    = 7'h64;
	localparam logic [6:0]  WAIT_RST    = 7'h32;
	// speeds in rpm
	localparam int          SPEED_W     = 14;
	localparam logic [13:0] SPEED_MAX   = 14'h2710;
	localparam logic [13:0] SPEED_RST   = 14'h0064;
	localparam logic [13:0] MAXSPD_RST  = 14'h1770;
	// option monitor selectors
	localparam int          MON_SEL_W   = 16;
	localparam logic [15:0] MON_RST     = 16'h0000;
	localparam int          MON_SRC_N   = 8;
	// status register bits
	localparam int          ST_DRIVE    = 0;
	localparam int          ST_BRK_REL  = 1;
	localparam int          ST_DB       = 2;
	localparam int          ST_COMM_ALM = 3;
	localparam int          ST_WDT_ALM  = 4;
	localparam int          ST_STATE    = 8;
	// tick of 10 ms at 100 MHz
	localparam int          CLK_HZ      = 100000000;
	localparam int          TICK_MS     = 10;
	localparam int          TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	// bus responses
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum logic [3:0]
	{
		S_OFF       = 4'h1,
		S_ON        = 4'h2,
		S_STOP_DLY  = 4'h4,
		S_MOVE_WAIT = 4'h8
	} ssq_state_t;
endpackage

// file: design/ssq_brake_stop_sequencer.sv
// stop mode, holding brake and comm check sequencer with axi4-lite regs
//
// Contract
// - setting 0 checks comm and watchdog errors
// - setting 1 mutes comm alarm, drops bad frames
// - setting 2 mutes watchdog alarm, keeps frames
// - setting 3 mutes both alarms
// - two monitor selectors, default 0000, immediate
// - off on command, alarm or power loss
// - mode 0: dynamic brake, held after stop
// - mode 1: dynamic brake, then coast
// - mode 2: drive off, coast, no brake
// - brake pin low releases, high applies
// - terminal select 0 off, 1..3 pairs
// - shared output circuit is OR of functions
// - brake-to-off delay 0..50 ticks, immediate
// - zero delay: off with brake same cycle
// - delay only when stopped; moving uses others
// - alarm turns drive off at once
// - moving: brake when speed below threshold
// - moving: brake after wait time, first wins
// - threshold capped at maximum motor speed
`timescale 1ns/1ps
module ssq_brake_stop_sequencer
#(
	parameter int          TICK_CYCLES       = ssq_pkg::TICK_CYCLES,
	parameter int          MON_SRC_N         = ssq_pkg::MON_SRC_N,
	parameter logic [13:0] MAX_SPEED_DEFAULT = ssq_pkg::MAXSPD_RST
)
(
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic [ssq_pkg::ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [ssq_pkg::ADDR_W-1:0]    s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	input  wire logic                          servo_on_command,
	input  wire logic                          servo_off_command,
	input  wire logic                          servo_alarm,
	input  wire logic                          main_power_ok,
	input  wire logic [ssq_pkg::SPEED_W-1:0]   motor_speed,
	input  wire logic                          rx_frame_valid,
	input  wire logic                          rx_comm_error,
	input  wire logic                          rx_wdt_error,
	input  wire logic [MON_SRC_N*32-1:0]       monitor_sources,
	input  wire logic [2:0]                    other_output_funcs,
	output logic                               motor_drive_enable,
	output logic                               dynamic_brake,
	output logic                               brake_interlock_output,
	output logic [2:0]                         output_circuit,
	output logic                               rx_frame_accept,
	output logic                               comm_alarm,
	output logic                               wdt_alarm,
	output logic [31:0]                        option_monitor_field_a,
	output logic [31:0]                        option_monitor_field_b
);
	import ssq_pkg::*;

	localparam int TW = $clog2(TICK_CYCLES + 1);

	generate
		if (TICK_CYCLES < 1 || MON_SRC_N < 1 || MON_SRC_N > 65535)
		begin : g_bad_params
			$error("ssq: unsupported parameter values");
		end
	endgenerate

	// configuration
	logic [1:0]           comm_check_control;
	logic [1:0]           stop_mode_select;
	logic [1:0]           brake_output_terminal_select;
	logic [DELAY_W-1:0]   brake_to_servo_off_delay;
	logic [SPEED_W-1:0]   brake_speed_threshold;
	logic [WAIT_W-1:0]    brake_wait_time;
	logic [MON_SEL_W-1:0] option_monitor_select_a;
	logic [MON_SEL_W-1:0] option_monitor_select_b;
	logic [SPEED_W-1:0]   max_speed;

	// sequencer
	ssq_state_t           state;
	ssq_state_t           next_state;
	logic                 next_drive;
	logic                 next_brake_rel;
	logic [TW-1:0]        tick_div;
	logic                 tick;
	logic [WAIT_W-1:0]    step_cnt;
	logic                 off_event;
	logic                 hard_off;
	logic                 moving;
	logic [SPEED_W-1:0]   eff_threshold;

	// bus slave
	logic [ADDR_W-1:0]    wr_addr;
	logic [31:0]          wr_data;
	logic [3:0]           wr_strb;
	logic                 do_write;
	logic                 wr_hit;
	logic [31:0]          rd_word;
	logic                 rd_hit;

	function automatic logic [31:0] merge
	(
		input logic [31:0] old,
		input logic [31:0] data,
		input logic [3:0]  strb
	);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic [31:0] clamp
	(
		input logic [31:0] v,
		input logic [31:0] lo,
		input logic [31:0] hi
	);
		logic [31:0] res;
		res = v;
		if (v < lo)
		begin
			res = lo;
		end
		else if (v > hi)
		begin
			res = hi;
		end
		return res;
	endfunction

	function automatic logic [31:0] pick
	(
		input logic [MON_SEL_W-1:0]    sel,
		input logic [MON_SRC_N*32-1:0] src
	);
		logic [31:0] res;
		res = 32'h00000000;
		for (int i = 0; i < MON_SRC_N; i++)
		begin
			if (32'(sel) == i)
			begin
				res = src[i*32 +: 32];
			end
		end
		return res;
	endfunction

	// ---------------- axi4-lite write channel
	assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	always_comb
	begin
		case (wr_addr)
			OFF_CTRL, OFF_DELAY, OFF_SPEED, OFF_WAIT,
			OFF_MON_A, OFF_MON_B, OFF_MAXSPD, OFF_STATUS:
				wr_hit = 1'b1;
			default:
				wr_hit = 1'b0;
		endcase
	end

	// address and data are caught in either order, then written together
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			wr_addr       <= '0;
			wr_data       <= 32'h00000000;
			wr_strb       <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				wr_addr       <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wr_data      <= s_axi_wdata;
				wr_strb      <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// configuration registers; out-of-range writes saturate to the range
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			comm_check_control           <= CC_RST;
			stop_mode_select             <= SM_RST;
			brake_output_terminal_select <= BT_RST;
			brake_to_servo_off_delay     <= DELAY_RST;
			brake_speed_threshold        <= SPEED_RST;
			brake_wait_time              <= WAIT_RST;
			option_monitor_select_a      <= MON_RST;
			option_monitor_select_b      <= MON_RST;
			max_speed                    <= MAX_SPEED_DEFAULT;
		end
		else if (do_write)
		begin
			case (wr_addr)
				OFF_CTRL:
				begin
					comm_check_control <= merge(32'(comm_check_control)
						<< CTRL_CC_LSB, wr_data, wr_strb)
						[CTRL_CC_LSB +: 2];
					stop_mode_select <= merge(32'(stop_mode_select)
						<< CTRL_SM_LSB, wr_data, wr_strb)
						[CTRL_SM_LSB +: 2];
					brake_output_terminal_select <= merge(
						32'(brake_output_terminal_select) << CTRL_BT_LSB,
						wr_data, wr_strb)[CTRL_BT_LSB +: 2];
				end
				OFF_DELAY:
					brake_to_servo_off_delay <= DELAY_W'(clamp(
						merge(32'(brake_to_servo_off_delay), wr_data,
						wr_strb), 32'h0, 32'(DELAY_MAX)));
				OFF_SPEED:
					brake_speed_threshold <= SPEED_W'(clamp(
						merge(32'(brake_speed_threshold), wr_data, wr_strb),
						32'h0, 32'(SPEED_MAX)));
				OFF_WAIT:
					brake_wait_time <= WAIT_W'(clamp(
						merge(32'(brake_wait_time), wr_data, wr_strb),
						32'(WAIT_MIN), 32'(WAIT_MAX)));
				OFF_MON_A:
					option_monitor_select_a <= MON_SEL_W'(merge(
						32'(option_monitor_select_a), wr_data, wr_strb));
				OFF_MON_B:
					option_monitor_select_b <= MON_SEL_W'(merge(
						32'(option_monitor_select_b), wr_data, wr_strb));
				OFF_MAXSPD:
					max_speed <= SPEED_W'(clamp(merge(32'(max_speed),
						wr_data, wr_strb), 32'h0, 32'(SPEED_MAX)));
				default:
				begin
				end
			endcase
		end
	end

	// ---------------- axi4-lite read channel
	always_comb
	begin
		rd_hit  = 1'b1;
		rd_word = 32'h00000000;
		case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
			OFF_CTRL:
			begin
				rd_word[CTRL_CC_LSB +: 2] = comm_check_control;
				rd_word[CTRL_SM_LSB +: 2] = stop_mode_select;
				rd_word[CTRL_BT_LSB +: 2] = brake_output_terminal_select;
			end
			OFF_DELAY:  rd_word = 32'(brake_to_servo_off_delay);
			OFF_SPEED:  rd_word = 32'(brake_speed_threshold);
			OFF_WAIT:   rd_word = 32'(brake_wait_time);
			OFF_MON_A:  rd_word = 32'(option_monitor_select_a);
			OFF_MON_B:  rd_word = 32'(option_monitor_select_b);
			OFF_MAXSPD: rd_word = 32'(max_speed);
			OFF_STATUS:
			begin
				rd_word[ST_DRIVE]     = motor_drive_enable;
				rd_word[ST_BRK_REL]   = !brake_interlock_output;
				rd_word[ST_DB]        = dynamic_brake;
				rd_word[ST_COMM_ALM]  = comm_alarm;
				rd_word[ST_WDT_ALM]   = wdt_alarm;
				rd_word[ST_STATE +: 4] = state;
			end
			default:    rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ---------------- fieldbus receive checks
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rx_frame_accept <= 1'b0;
			comm_alarm      <= 1'b0;
			wdt_alarm       <= 1'b0;
		end
		else
		begin
			// comm-error frames are never used, only the alarm is muted
			rx_frame_accept <= rx_frame_valid && !rx_comm_error
				&& (!rx_wdt_error || comm_check_control[1]);
			// set wins over a write-one clear in the same cycle
			if (rx_frame_valid && rx_comm_error && !comm_check_control[0])
			begin
				comm_alarm <= 1'b1;
			end
			else if (do_write && wr_addr == OFF_STATUS && wr_strb[0]
				&& wr_data[ST_COMM_ALM])
			begin
				comm_alarm <= 1'b0;
			end
			if (rx_frame_valid && rx_wdt_error && !comm_check_control[1])
			begin
				wdt_alarm <= 1'b1;
			end
			else if (do_write && wr_addr == OFF_STATUS && wr_strb[0]
				&& wr_data[ST_WDT_ALM])
			begin
				wdt_alarm <= 1'b0;
			end
		end
	end

	// ---------------- option monitor
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			option_monitor_field_a <= 32'h00000000;
			option_monitor_field_b <= 32'h00000000;
		end
		else
		begin
			// unknown selections read as zero
			option_monitor_field_a <= pick(option_monitor_select_a,
				monitor_sources);
			option_monitor_field_b <= pick(option_monitor_select_b,
				monitor_sources);
		end
	end

	// ---------------- tick and step counter
	assign tick = (tick_div == TW'(TICK_CYCLES - 1));

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tick_div <= '0;
			step_cnt <= '0;
		end
		else if (state == S_ON || state == S_OFF)
		begin
			// restarted so the first step ends one tick after the event
			tick_div <= '0;
			step_cnt <= '0;
		end
		else
		begin
			tick_div <= tick ? '0 : tick_div + TW'(1);
			if (tick && step_cnt != WAIT_MAX)
			begin
				step_cnt <= step_cnt + WAIT_W'(1);
			end
		end
	end

	// ---------------- stop sequence
	assign hard_off      = servo_alarm || !main_power_ok;
	assign off_event     = servo_off_command || hard_off;
	assign moving        = motor_speed != '0;
	assign eff_threshold = (brake_speed_threshold > max_speed)
		? max_speed : brake_speed_threshold;

	always_comb
	begin
		next_state     = state;
		next_drive     = motor_drive_enable;
		next_brake_rel = !brake_interlock_output;
		case (state)
			S_OFF:
			begin
				next_drive     = 1'b0;
				next_brake_rel = 1'b0;
				if (servo_on_command && !off_event)
				begin
					next_state     = S_ON;
					next_drive     = 1'b1;
					next_brake_rel = 1'b1;
				end
			end
			S_ON:
			begin
				if (off_event && moving)
				begin
					// brake stays released until slow or timed out
					next_state = S_MOVE_WAIT;
					next_drive = 1'b0;
				end
				else if (off_event)
				begin
					next_brake_rel = 1'b0;
					if (hard_off || brake_to_servo_off_delay == '0)
					begin
						next_state = S_OFF;
						next_drive = 1'b0;
					end
					else
					begin
						next_state = S_STOP_DLY;
					end
				end
			end
			S_STOP_DLY:
			begin
				next_brake_rel = 1'b0;
				if (hard_off
					|| step_cnt >= WAIT_W'(brake_to_servo_off_delay))
				begin
					next_state = S_OFF;
					next_drive = 1'b0;
				end
			end
			S_MOVE_WAIT:
			begin
				next_drive = 1'b0;
				if (motor_speed < eff_threshold
					|| step_cnt >= brake_wait_time)
				begin
					next_state     = S_OFF;
					next_brake_rel = 1'b0;
				end
			end
			default:
			begin
				next_state     = S_OFF;
				next_drive     = 1'b0;
				next_brake_rel = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state                  <= S_OFF;
			motor_drive_enable     <= 1'b0;
			brake_interlock_output <= 1'b1;
			dynamic_brake          <= 1'b0;
			output_circuit         <= 3'h0;
		end
		else
		begin
			state                  <= next_state;
			motor_drive_enable     <= next_drive;
			brake_interlock_output <= !next_brake_rel;
			// mode 1 lets go once stopped; 2 and 3 never brake
			dynamic_brake <= !next_drive
				&& (stop_mode_select == SM_DB_HOLD
				|| (stop_mode_select == SM_DB_FREE && moving));
			for (int i = 0; i < 3; i++)
			begin
				output_circuit[i] <= other_output_funcs[i]
					|| (next_brake_rel
					&& brake_output_terminal_select == 2'(i + 1));
			end
		end
	end
endmodule

// file: verification/ssq_checker_sva.sv
// port assertions for the brake and stop sequencer
`timescale 1ns/1ps
module ssq_checker
#(
	parameter int TICK_CYCLES = 4
)
(
	input wire logic                        aclk,
	input wire logic                        aresetn,
	input wire logic                        servo_on_command,
	input wire logic                        servo_off_command,
	input wire logic                        servo_alarm,
	input wire logic                        main_power_ok,
	input wire logic [ssq_pkg::SPEED_W-1:0] motor_speed,
	input wire logic                        rx_frame_valid,
	input wire logic                        rx_comm_error,
	input wire logic                        rx_wdt_error,
	input wire logic [2:0]                  other_output_funcs,
	input wire logic                        motor_drive_enable,
	input wire logic                        dynamic_brake,
	input wire logic                        brake_interlock_output,
	input wire logic [2:0]                  output_circuit,
	input wire logic                        rx_frame_accept
);
	import ssq_pkg::*;
	// longest wait of 100 steps plus entry slack
	localparam int MW_LIM = 101 * TICK_CYCLES + 4;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_idle_on;
		servo_on_command && !servo_off_command && !servo_alarm
			&& main_power_ok && !motor_drive_enable
			&& brake_interlock_output;
	endsequence
	sequence s_running;
		motor_drive_enable && !brake_interlock_output;
	endsequence
	sequence s_move_off;
		$fell(motor_drive_enable) && !brake_interlock_output;
	endsequence
	a_servo_start: assert property (s_idle_on |=> s_running)
		else $error("servo on not honoured");
	a_alarm_cut: assert property (servo_alarm && motor_drive_enable
		|=> !motor_drive_enable)
		else $error("drive kept on alarm");
	a_stop_same: assert property (s_running and
		(servo_alarm && motor_speed == 0)
		|=> brake_interlock_output && !motor_drive_enable)
		else $error("stopped alarm not braking at once");
	a_move_hold: assert property (s_running and
		(servo_off_command && motor_speed != 0)
		|=> !brake_interlock_output && !motor_drive_enable)
		else $error("moving stop braked early");
	a_move_brake: assert property (s_move_off
		|-> ##[1:MW_LIM] brake_interlock_output)
		else $error("brake not applied within wait");
	a_db_drive: assert property (motor_drive_enable
		&& $past(motor_drive_enable) |-> !dynamic_brake)
		else $error("dynamic brake while driving");
	a_circ_or: assert property (brake_interlock_output &&
		$past(brake_interlock_output) && $past(aresetn)
		|-> output_circuit == $past(other_output_funcs))
		else $error("output circuit not plain other funcs");
	a_frame_ok: assert property (rx_frame_valid && !rx_comm_error
		&& !rx_wdt_error |=> rx_frame_accept)
		else $error("clean frame dropped");
	a_frame_bad: assert property (rx_frame_valid && rx_comm_error
		|=> !rx_frame_accept)
		else $error("bad frame accepted");
	a_no_frame: assert property (!rx_frame_valid |=> !rx_frame_accept)
		else $error("accept without frame");
endmodule
bind ssq_brake_stop_sequencer ssq_checker #(.TICK_CYCLES(TICK_CYCLES))
	u_chk (.*);

// file: verification/ssq_host_model.sv
// host controller model: servo commands and fieldbus frames
`timescale 1ns/1ps
module ssq_host_model
(
	input  wire logic aclk,
	output logic      servo_on_command,
	output logic      servo_off_command,
	output logic      rx_frame_valid,
	output logic      rx_comm_error,
	output logic      rx_wdt_error
);
	initial
	begin
		servo_on_command  = 1'b0;
		servo_off_command = 1'b0;
		rx_frame_valid    = 1'b0;
		rx_comm_error     = 1'b0;
		rx_wdt_error      = 1'b0;
	end
	task automatic pulse_cmd(input logic on);
		@(posedge aclk);
		if (on)
			servo_on_command <= 1'b1;
		else
			servo_off_command <= 1'b1;
		@(posedge aclk);
		servo_on_command  <= 1'b0;
		servo_off_command <= 1'b0;
	endtask
	// error flags mean nothing outside a frame, so scramble them there
	task automatic send_frame(input logic ce, input logic we);
		@(posedge aclk);
		rx_frame_valid <= 1'b1;
		rx_comm_error  <= ce;
		rx_wdt_error   <= we;
		@(posedge aclk);
		rx_frame_valid <= 1'b0;
		rx_comm_error  <= ~ce;
		rx_wdt_error   <= ~we;
	endtask
endmodule

// file: verification/tb_top.sv
// self-checking testbench of the brake and stop sequencer
`timescale 1ns/1ps
module tb_top;
	import ssq_pkg::*;
	localparam int TK = 4;
	logic              aclk, aresetn, servo_alarm, main_power_ok;
	logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic              s_axi_rready, servo_on_command, servo_off_command;
	logic              rx_frame_valid, rx_comm_error, rx_wdt_error;
	logic              motor_drive_enable, dynamic_brake, rx_frame_accept;
	logic              brake_interlock_output, comm_alarm, wdt_alarm;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0]       s_axi_wdata, s_axi_rdata;
	logic [31:0]       option_monitor_field_a, option_monitor_field_b;
	logic [3:0]        s_axi_wstrb;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	logic [SPEED_W-1:0] motor_speed;
	logic [2:0]        other_output_funcs, output_circuit;
	logic [255:0]      monitor_sources;
	int                failures, n_tests, cycles;

	ssq_brake_stop_sequencer #(.TICK_CYCLES(TK)) DUT (.*);
	ssq_host_model u_host (.*);

	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	task automatic complete_run();
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			complete_run();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			failures++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chkb(input logic g, input logic e);
		chk({31'h0, g}, {31'h0, e});
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata   <= d;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		#1;
	endtask
	task automatic rchk(input logic [5:0] a, input logic [31:0] e,
		input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		chk(s_axi_rdata, e);
		chk({30'h0, s_axi_rresp}, {30'h0, er});
		s_axi_rready <= 1'b0;
	endtask
	// alarm or power loss, one cycle long
	task automatic trip(input logic pwr);
		@(posedge aclk);
		if (pwr)
			main_power_ok <= 1'b0;
		else
			servo_alarm <= 1'b1;
		@(posedge aclk);
		main_power_ok <= 1'b1;
		servo_alarm   <= 1'b0;
		#1;
	endtask
	task automatic t_regs();
		logic [31:0] rv [7] = '{32'h10, 32'h0, 32'h64, 32'h32, 32'h0,
			32'h0, 32'h1770};
		for (int i = 0; i < 7; i++)
			rchk(6'(4 * i), rv[i], RESP_OKAY);
		rchk(6'h20, 32'h0, RESP_SLVERR);
		wr(OFF_DELAY, 32'h3F);
		rchk(OFF_DELAY, 32'h32, RESP_OKAY);
		wr(OFF_WAIT, 32'h5);
		rchk(OFF_WAIT, 32'hA, RESP_OKAY);
		// byte strobe: only the low byte of the threshold may change
		s_axi_wstrb <= 4'h1;
		wr(OFF_SPEED, 32'hFFFFFF20);
		s_axi_wstrb <= 4'hF;
		rchk(OFF_SPEED, 32'h20, RESP_OKAY);
		wr(OFF_SPEED, 32'h64);
		wr(OFF_DELAY, 32'h0);
	endtask
	task automatic t_comm();
		logic [1:0] s;
		for (int i = 0; i < 4; i++)
		begin
			s = 2'(i);
			wr(OFF_CTRL, 32'(16 + i));
			u_host.send_frame(1'b0, 1'b0);
			#1;
			chkb(rx_frame_accept, 1'b1);
			u_host.send_frame(1'b1, 1'b0);
			#1;
			chkb(rx_frame_accept, 1'b0);
			chkb(comm_alarm, !s[0]);
			u_host.send_frame(1'b0, 1'b1);
			#1;
			chkb(rx_frame_accept, s[1]);
			chkb(wdt_alarm, !s[1]);
			wr(OFF_STATUS, 32'h18);
			chkb(comm_alarm | wdt_alarm, 1'b0);
		end
		wr(OFF_MON_A, 32'h3);
		wr(OFF_MON_B, 32'h7);
		@(posedge aclk);
		#1;
		chk(option_monitor_field_a, 32'h5A000003);
		chk(option_monitor_field_b, 32'h5A000007);
		monitor_sources[32 * 3 +: 32] <= 32'h12345678;
		repeat (2) @(posedge aclk);
		#1;
		chk(option_monitor_field_a, 32'h12345678);
	endtask
	task automatic t_stop();
		for (int m = 0; m < 3; m++)
		begin
			wr(OFF_CTRL, 32'(16 + 4 * m));
			u_host.pulse_cmd(1'b1);
			#1;
			chkb(motor_drive_enable, 1'b1);
			chkb(brake_interlock_output, 1'b0);
			u_host.pulse_cmd(1'b0);
			#1;
			chkb(brake_interlock_output, 1'b1);
			chkb(motor_drive_enable, 1'b0);
			@(posedge aclk);
			#1;
			chkb(dynamic_brake, m == 0);
		end
		wr(OFF_DELAY, 32'h3);
		u_host.pulse_cmd(1'b1);
		u_host.pulse_cmd(1'b0);
		#1;
		chkb(brake_interlock_output, 1'b1);
		repeat (3 * TK - 2) @(posedge aclk);
		#1;
		chkb(motor_drive_enable, 1'b1);
		repeat (5) @(posedge aclk);
		#1;
		chkb(motor_drive_enable, 1'b0);
		wr(OFF_DELAY, 32'h32);
		u_host.pulse_cmd(1'b1);
		u_host.pulse_cmd(1'b0);
		#1;
		chkb(motor_drive_enable, 1'b1);
		trip(1'b0);
		chkb(motor_drive_enable, 1'b0);
		for (int p = 0; p < 2; p++)
		begin
			u_host.pulse_cmd(1'b1);
			trip(1'(p));
			chkb(motor_drive_enable, 1'b0);
			chkb(brake_interlock_output, 1'b1);
		end
		wr(OFF_DELAY, 32'h0);
	endtask
	task automatic t_move();
		wr(OFF_CTRL, 32'h14);
		wr(OFF_SPEED, 32'h2328);
		wr(OFF_MAXSPD, 32'h3E8);
		wr(OFF_WAIT, 32'h64);
		for (int k = 0; k < 2; k++)
		begin
			@(posedge aclk);
			motor_speed <= 14'h5DC;
			u_host.pulse_cmd(1'b1);
			u_host.pulse_cmd(1'b0);
			repeat (2) @(posedge aclk);
			#1;
			chkb(brake_interlock_output, 1'b0);
			chkb(dynamic_brake, 1'b1);
			if (k == 0)
			begin
				@(posedge aclk);
				motor_speed <= 14'h384;
				repeat (2) @(posedge aclk);
			end
			else
				repeat (10 * TK + 6) @(posedge aclk);
			#1;
			chkb(brake_interlock_output, 1'b1);
			wr(OFF_WAIT, 32'hA);
		end
		@(posedge aclk);
		motor_speed <= 14'h0;
		repeat (2) @(posedge aclk);
		#1;
		chkb(dynamic_brake, 1'b0);
		wr(OFF_SPEED, 32'h64);
		wr(OFF_MAXSPD, 32'h1770);
	endtask
	task automatic t_term();
		logic [2:0] e;
		u_host.pulse_cmd(1'b1);
		for (int t = 0; t < 4; t++)
		begin
			e = (t == 0) ? 3'h0 : 3'(1 << (t - 1));
			wr(OFF_CTRL, 32'(16 * t));
			@(posedge aclk);
			#1;
			chk({29'h0, output_circuit}, {29'h0, e});
		end
		@(posedge aclk);
		other_output_funcs <= 3'h1;
		repeat (2) @(posedge aclk);
		#1;
		chk({29'h0, output_circuit}, 32'h5);
		u_host.pulse_cmd(1'b0);
		repeat (2) @(posedge aclk);
		#1;
		chk({29'h0, output_circuit}, 32'h1);
		other_output_funcs <= 3'h0;
	endtask
	initial
	begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, servo_alarm} = 3'h0;
		s_axi_awaddr = 6'h0;
		s_axi_araddr = 6'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		main_power_ok = 1'b1;
		motor_speed = 14'h0;
		other_output_funcs = 3'h0;
		for (int i = 0; i < 8; i++)
			monitor_sources[32 * i +: 32] = 32'h5A000000 | 32'(i);
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_comm();
		t_stop();
		t_move();
		t_term();
		complete_run();
	end
endmodule
